// [shared/ep_buffer_regs.vh]
// Command codes, status bit positions and reset values for endpoint control
`ifndef EP_BUFFER_REGS_VH
`define EP_BUFFER_REGS_VH

// Command groups, upper nibble of the command code; CMD_ACK_SETUP is a full code
`define CMD_STALL 4'h4
`define CMD_STATUS 4'h5
`define CMD_VALIDATE 4'h6
`define CMD_CLEAR 4'h7
`define CMD_UNSTALL 4'h8
`define CMD_SNAPSHOT 4'hd
`define CMD_ACK_SETUP 8'hf4

// Endpoint indices in the lower nibble
`define EP_CTRL_OUT 4'h0
`define EP_CTRL_IN 4'h1

// Status byte field positions
`define ST_STALLED 7
`define ST_SEC_FULL 6
`define ST_PRI_FULL 5
`define ST_TOGGLE 4
`define ST_REPLACED 3
`define ST_SETUP 2
`define ST_BUF_SEL 1
`define ST_RESERVED 0

// Reset values
`define STATUS_RESET 8'h00
`define RD_DATA_RESET 16'h0000
`define FLAGS_RESET 16'h0000

`endif

// [sim/ep_buffer_control_monitor.sv]
// Port-level assertions for endpoint buffer control
`timescale 1ns/1ns
module ep_buffer_control_monitor
(
    input logic sys_clk,
    input logic sys_rst,
    input logic cmd_wr,
    input logic [7:0] cmd_code,
    input logic data_rd,
    input logic [15:0] rd_data,
    input logic rd_pending,
    input logic [3:0] usb_ep,
    input logic usb_setup,
    input logic [15:0] ep_stalled,
    input logic [15:0] device_interrupt_flags,
    input logic setup_locked
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    logic stall_sel_reg;
    logic snap_open_reg;
    always @(posedge sys_clk)
        stall_sel_reg <= ep_stalled[cmd_code[3:0]];
    // Whether the pending data phase belongs to a snapshot
    always @(posedge sys_clk)
        if (cmd_wr && (cmd_code[7:4] == 4'h5 || cmd_code[7:4] == 4'hd))
            snap_open_reg <= (cmd_code[7:4] == 4'hd);
    sequence status_cmd;
        cmd_wr && (cmd_code[7:4] == 4'h5 || cmd_code[7:4] == 4'hd);
    endsequence
    sequence snap_cmd;
        cmd_wr && cmd_code[7:4] == 4'hd && !usb_setup;
    endsequence
    sequence setup_in;
        usb_setup && usb_ep == 4'h0;
    endsequence
    read_arm_a: assert property (status_cmd |=> rd_pending)
        else $error("no data phase after status command");
    read_done_a: assert property
        (rd_pending && data_rd && !cmd_wr |=> !rd_pending)
        else $error("data phase not closed");
    upper_zero_a: assert property
        (rd_pending |-> rd_data[15:8] == 8'h00)
        else $error("upper read byte not zero");
    reserved_bit_a: assert property (rd_pending |-> !rd_data[0])
        else $error("reserved status bit set");
    stall_bit_a: assert property
        (snap_cmd ##1 1 |-> rd_data[7] == stall_sel_reg)
        else $error("stall bit wrong");
    snap_keeps_a: assert property
        (rd_pending && data_rd && snap_open_reg |=>
        (device_interrupt_flags & $past(device_interrupt_flags)) ==
        $past(device_interrupt_flags)) else $error("snapshot cleared");
    setup_lock_a: assert property (setup_in |=> setup_locked)
        else $error("setup lock missing");
    ack_unlock_a: assert property
        (cmd_wr && cmd_code == 8'hf4 && !usb_setup |=> !setup_locked)
        else $error("acknowledge left lock");
    setup_unstall_a: assert property
        (setup_in and !cmd_wr |=> ep_stalled[1:0] == 2'b00)
        else $error("setup left stall");
endmodule // ep_buffer_control_monitor
bind ep_buffer_control ep_buffer_control_monitor u_mon
(
    .sys_clk(sys_clk), .sys_rst(sys_rst), .cmd_wr(cmd_wr),
    .cmd_code(cmd_code), .data_rd(data_rd), .rd_data(rd_data),
    .rd_pending(rd_pending), .usb_ep(usb_ep), .usb_setup(usb_setup),
    .ep_stalled(ep_stalled), .device_interrupt_flags(device_interrupt_flags),
    .setup_locked(setup_locked)
);

// [sim/ep_buffer_control_tb.sv]
// Self-checking bench for endpoint buffer control
`timescale 1ns/1ns
module ep_buffer_control_tb;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic cmd_wr = 1'b0;
    logic [7:0] cmd_code = 8'h00;
    logic data_rd = 1'b0;
    logic [15:0] rd_data, ep_nak, ep_stalled, flags;
    logic rd_pending, setup_locked, usb_done, usb_setup, setup_busy;
    logic [3:0] usb_ep;
    logic [15:0] ep_is_in = 16'h000a;
    logic [15:0] ep_dbl_buf = 16'h0008;
    integer err_total = 0;
    integer total_checks = 0;
    integer cycles = 0;
    always #20 sys_clk = ~sys_clk;
    usb_host_model u_host (.sys_clk(sys_clk), .usb_ep(usb_ep),
        .usb_done(usb_done), .usb_setup(usb_setup), .setup_busy(setup_busy));
    ep_buffer_control u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .cmd_wr(cmd_wr), .cmd_code(cmd_code), .data_rd(data_rd),
        .rd_data(rd_data), .rd_pending(rd_pending), .usb_ep(usb_ep),
        .usb_done(usb_done), .usb_setup(usb_setup), .setup_busy(setup_busy),
        .ep_is_in(ep_is_in), .ep_dbl_buf(ep_dbl_buf), .ep_nak(ep_nak),
        .ep_stalled(ep_stalled), .device_interrupt_flags(flags),
        .setup_locked(setup_locked));
    task automatic check(input logic [15:0] seen, exp, input string nm);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cmd(input logic [7:0] c);
        @(posedge sys_clk);
        cmd_wr <= 1'b1;
        cmd_code <= c;
        @(posedge sys_clk);
        cmd_wr <= 1'b0;
    endtask
    // Status word read with its data phase
    task automatic rd(input logic [7:0] c, input logic [7:0] exp);
        cmd(c);
        #1 check(rd_data, {8'h00, exp}, "status word");
        @(posedge sys_clk);
        data_rd <= 1'b1;
        @(posedge sys_clk);
        data_rd <= 1'b0;
        #1 check({15'h0, rd_pending}, 16'h0, "pending");
    endtask
    task automatic t_reset();
        rd(8'hd5, 8'h00);
        check(ep_nak, ep_is_in, "nak after reset");
    endtask
    task automatic t_validate();
        cmd(8'h60);
        rd(8'hd0, 8'h00);
        cmd(8'h63);
        #1 check({15'h0, ep_nak[3]}, 16'h0, "in nak");
        rd(8'hd3, 8'h22);
    endtask
    task automatic t_out();
        u_host.pulse(4'h2, 1'b0);
        #1 check({15'h0, ep_nak[2]}, 16'h1, "out nak");
        rd(8'hd2, 8'h30);
        u_host.pulse(4'h2, 1'b0);
        rd(8'hd2, 8'h30);
        check({15'h0, flags[2]}, 16'h1, "flag kept");
        cmd(8'h71);
        cmd(8'h72);
        rd(8'hd2, 8'h10);
        rd(8'h52, 8'h10);
        check({15'h0, flags[2]}, 16'h0, "flag cleared");
    endtask
    task automatic t_setup();
        u_host.pulse(4'h0, 1'b1);
        #1 check({15'h0, setup_locked}, 16'h1, "locked");
        rd(8'hd0, 8'h24);
        cmd(8'h61);
        rd(8'hd1, 8'h00);
        cmd(8'h70);
        rd(8'hd0, 8'h24);
        u_host.pulse(4'h0, 1'b1);
        rd(8'hd0, 8'h2c);
        rd(8'h50, 8'h2c);
        rd(8'hd0, 8'h24);
        cmd(8'hf4);
        #1 check({15'h0, setup_locked}, 16'h0, "unlocked");
        cmd(8'h61);
        rd(8'hd1, 8'h20);
        cmd(8'h71);
        rd(8'hd1, 8'h20);
        cmd(8'h41);
        rd(8'hd1, 8'ha0);
        u_host.pulse(4'h0, 1'b1);
        rd(8'hd1, 8'h00);
    endtask
    // Replaced bit survives a clearing read while setup data is stored
    task automatic t_busy();
        u_host.pulse(4'h0, 1'b1);
        u_host.busy(1'b1);
        rd(8'h50, 8'h2c);
        rd(8'hd0, 8'h2c);
        u_host.busy(1'b0);
        rd(8'h50, 8'h2c);
        rd(8'hd0, 8'h24);
    endtask
    // Reset in mid-run from a non-zero state
    task automatic t_rerst();
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        #1 check(flags, 16'h0000, "flags after reset");
        check({15'h0, setup_locked}, 16'h0, "lock after reset");
        rd(8'hd0, 8'h00);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Whole run needs well under a thousand cycles
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            err_total++;
            results();
        end
    end
    initial
    begin
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_validate();
        t_out();
        t_setup();
        t_busy();
        t_rerst();
        results();
    end
endmodule // ep_buffer_control_tb

// [sim/usb_host_model.sv]
// USB host side event model for endpoint buffer control
`timescale 1ns/1ns
module usb_host_model
(
    // Clock
    input logic sys_clk,
    // Engine events
    output logic [3:0] usb_ep,
    output logic usb_done,
    output logic usb_setup,
    output logic setup_busy
);
    initial
    begin
        usb_ep = 4'h0;
        usb_done = 1'b0;
        usb_setup = 1'b0;
        setup_busy = 1'b0;
    end

    // One-cycle pulse; the endpoint is held with the strobe
    task automatic pulse(input logic [3:0] ep, input logic setup);
        @(posedge sys_clk);
        usb_ep <= ep;
        usb_done <= ~setup;
        usb_setup <= setup;
        @(posedge sys_clk);
        usb_done <= 1'b0;
        usb_setup <= 1'b0;
        usb_ep <= ~ep;
    endtask

    // Level: setup data still being stored, holds off the replaced clear
    task automatic busy(input logic b);
        @(posedge sys_clk);
        setup_busy <= b;
    endtask
endmodule // usb_host_model

// [src/cmd_decode.v]
// Command code decoder for the endpoint buffer commands
`timescale 1ns/1ns
`include "ep_buffer_regs.vh"

module cmd_decode
(
    // Command code
    input wire [7:0] code,
    // Decoded command
    output wire [3:0] ep_idx,
    output wire do_validate,
    output wire do_clear,
    output wire do_stall,
    output wire do_unstall,
    output wire do_status,
    output wire do_snapshot,
    output wire do_ack
);

    wire [3:0] group;

    assign group = code[7:4];
    assign ep_idx = code[3:0];

    // Validate has no control OUT form, clear no control IN form
    assign do_validate = (group == `CMD_VALIDATE) &&
        (ep_idx != `EP_CTRL_OUT);
    assign do_clear = (group == `CMD_CLEAR) &&
        (ep_idx != `EP_CTRL_IN);
    assign do_stall = (group == `CMD_STALL);
    assign do_unstall = (group == `CMD_UNSTALL);
    assign do_status = (group == `CMD_STATUS);
    assign do_snapshot = (group == `CMD_SNAPSHOT);
    assign do_ack = (code == `CMD_ACK_SETUP);

endmodule // cmd_decode

// [src/ep_buffer_control.v]
// Endpoint buffer control: command handling and per-endpoint state
//
// Summary of operation
// - Validate command sets the selected IN endpoint's buffer-full flag.
// - On double-buffered endpoints validate and clear swap processor buffer.
// - Validate covers control IN and 2-15; clear control OUT and 2-15.
// - Clear command empties and unlocks the selected OUT buffer.
// - A complete received OUT packet sets the buffer-full flag.
// - Full locked OUT buffer answers every further packet with NAK.
// - Snapshot read returns the status byte and clears nothing.
// - Snapshot codes cover all sixteen endpoints, one data word follows.
// - Status bit 7 is the stall indication.
// - Bit 6 secondary buffer full, bit 5 primary buffer full.
// - Bit 4 gives next expected data toggle, one for DATA1.
// - Bit 3 sets when a new SETUP replaces unacknowledged setup data.
// - Bit 3 clears on an ordinary status read once setup storing has finished.
// - Bit 2 shows the buffer holds a SETUP packet.
// - Bit 1 shows processor buffer select; bit 0 reads zero.
// - SETUP arrival blocks validate and clear on control endpoints.
// - Status fields reset to zero and are read-only.
// - Ordinary status read clears the endpoint's interrupt flag.
// - SETUP unstalls control endpoints, flushes them, returns to DATA0.
`timescale 1ns/1ns
`include "ep_buffer_regs.vh"

module ep_buffer_control
(
    // Clock and reset
    input wire sys_clk,
    input wire sys_rst,
    // Processor command port
    input wire cmd_wr,
    input wire [7:0] cmd_code,
    input wire data_rd,
    output reg [15:0] rd_data,
    output reg rd_pending,
    // USB engine events
    input wire [3:0] usb_ep,
    input wire usb_done,
    input wire usb_setup,
    input wire setup_busy,
    // Endpoint configuration
    input wire [15:0] ep_is_in,
    input wire [15:0] ep_dbl_buf,
    // Endpoint state
    output wire [15:0] ep_nak,
    output wire [15:0] ep_stalled,
    output reg [15:0] device_interrupt_flags,
    output reg setup_locked
);

    localparam [15:0] ONE_HOT = 16'h0001;

    wire [3:0] dec_ep;
    wire dec_validate;
    wire dec_clear;
    wire dec_stall;
    wire dec_unstall;
    wire dec_status;
    wire dec_snapshot;
    wire dec_ack;

    wire [15:0] cmd_sel;
    wire [15:0] usb_sel;
    wire [15:0] rd_sel;
    wire [127:0] all_status;
    wire setup_in;
    wire ctrl_blocked;
    wire gated_validate;
    wire gated_clear;
    wire rd_take;
    wire [15:0] int_set;
    wire [15:0] int_clr;
    wire [7:0] endpoint_status_snapshot;

    reg [3:0] rd_ep_reg;
    reg rd_clears_reg;
    reg [15:0] int_next;

    cmd_decode u_decode
    (
        .code(cmd_code),
        .ep_idx(dec_ep),
        .do_validate(dec_validate),
        .do_clear(dec_clear),
        .do_stall(dec_stall),
        .do_unstall(dec_unstall),
        .do_status(dec_status),
        .do_snapshot(dec_snapshot),
        .do_ack(dec_ack)
    );

    assign cmd_sel = ONE_HOT << dec_ep;
    assign usb_sel = ONE_HOT << usb_ep;
    assign rd_sel = ONE_HOT << rd_ep_reg;

    // SETUP tokens only land on the control OUT endpoint
    assign setup_in = usb_setup && (usb_ep == `EP_CTRL_OUT);

    // Control endpoints ignore buffer commands until acknowledged
    assign ctrl_blocked = setup_locked &&
        ((dec_ep == `EP_CTRL_OUT) || (dec_ep == `EP_CTRL_IN));

    // Buffer commands act on the command write itself
    assign gated_validate = cmd_wr && dec_validate &&
        !ctrl_blocked;
    assign gated_clear = cmd_wr && dec_clear && !ctrl_blocked;

    assign rd_take = data_rd && rd_pending;

    genvar i;
    generate
        for (i = 0; i < 16; i = i + 1)
        begin : g_ep
            wire is_ctrl;

            assign is_ctrl = (i < 2);

            ep_state u_ep
            (
                .sys_clk(sys_clk),
                .sys_rst(sys_rst),
                .is_in(ep_is_in[i]),
                .dbl_buf(ep_dbl_buf[i]),
                .cpu_validate(gated_validate && cmd_sel[i]),
                .cpu_clear(gated_clear && cmd_sel[i]),
                .cpu_stall(cmd_wr && dec_stall && cmd_sel[i]),
                .cpu_unstall(cmd_wr && dec_unstall && cmd_sel[i]),
                .replaced_clear(rd_take && rd_clears_reg && rd_sel[i]),
                .usb_done(usb_done && usb_sel[i] && !usb_setup),
                .usb_setup(setup_in && (i == 0)),
                .flush(setup_in && is_ctrl),
                .setup_pending(setup_locked),
                .setup_busy(setup_busy),
                .endpoint_status_byte(all_status[i*8 +: 8]),
                .usb_nak(ep_nak[i]),
                .ep_stalled(ep_stalled[i])
            );

            // Any completed transfer or SETUP flags the endpoint
            assign int_set[i] = (usb_done || usb_setup) && usb_sel[i];
            assign int_clr[i] = rd_take && rd_clears_reg &&
                rd_sel[i];
        end
    endgenerate

    assign endpoint_status_snapshot = all_status[dec_ep*8 +: 8];

    // Setup lock: a SETUP arriving with the acknowledge still wins
    always @(posedge sys_clk)
    begin
        if (sys_rst)
            setup_locked <= 1'b0;
        else if (setup_in)
            setup_locked <= 1'b1;
        else if (cmd_wr && dec_ack)
            setup_locked <= 1'b0;
    end

    // Interrupt flags, set beats clear
    always @*
    begin
        int_next = (device_interrupt_flags & ~int_clr) | int_set;
    end

    always @(posedge sys_clk)
    begin
        if (sys_rst)
            device_interrupt_flags <= `FLAGS_RESET;
        else
            device_interrupt_flags <= int_next;
    end

    // Read path: byte captured at the command, side effects on the read.
    // Capturing early keeps the word stable while the processor fetches it.
    always @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            rd_data <= `RD_DATA_RESET;
            rd_pending <= 1'b0;
            rd_ep_reg <= `EP_CTRL_OUT;
            rd_clears_reg <= 1'b0;
        end
        else if (cmd_wr && (dec_status || dec_snapshot))
        begin
            rd_data <= {8'h00, endpoint_status_snapshot};
            rd_pending <= 1'b1;
            rd_ep_reg <= dec_ep;
            // Snapshot reads leave every flag alone
            rd_clears_reg <= dec_status;
        end
        else if (rd_take)
        begin
            rd_pending <= 1'b0;
            rd_clears_reg <= 1'b0;
        end
    end

endmodule // ep_buffer_control

// [src/ep_state.v]
// Buffer, toggle, stall and setup state of one endpoint
`timescale 1ns/1ns
`include "ep_buffer_regs.vh"

module ep_state
(
    // Clock and reset
    input wire sys_clk,
    input wire sys_rst,
    // Configuration
    input wire is_in,
    input wire dbl_buf,
    // Processor commands, one-cycle pulses
    input wire cpu_validate,
    input wire cpu_clear,
    input wire cpu_stall,
    input wire cpu_unstall,
    input wire replaced_clear,
    // USB engine events, one-cycle pulses; setup_pending and setup_busy are levels
    input wire usb_done,
    input wire usb_setup,
    input wire flush,
    input wire setup_pending,
    input wire setup_busy,
    // State
    output wire [7:0] endpoint_status_byte,
    output wire usb_nak,
    output wire ep_stalled
);

    reg stall_reg;
    reg pri_full_reg;
    reg sec_full_reg;
    reg toggle_reg;
    reg replaced_reg;
    reg setup_reg;
    reg cpu_sel_reg;
    reg usb_sel_reg;
    wire usb_full;
    wire accept;

    assign usb_full = usb_sel_reg ? sec_full_reg : pri_full_reg;
    // Full OUT buffer refuses, empty IN buffer has nothing to send
    assign usb_nak = is_in ? !usb_full : usb_full;
    assign accept = usb_done && !stall_reg && !usb_nak;
    assign ep_stalled = stall_reg;

    assign endpoint_status_byte = {stall_reg, sec_full_reg, pri_full_reg,
        toggle_reg, replaced_reg, setup_reg, cpu_sel_reg,
        1'b0};

    always @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            stall_reg <= 1'b0;
            pri_full_reg <= 1'b0;
            sec_full_reg <= 1'b0;
            toggle_reg <= 1'b0;
            replaced_reg <= 1'b0;
            setup_reg <= 1'b0;
            cpu_sel_reg <= 1'b0;
            usb_sel_reg <= 1'b0;
        end
        else
        begin
            if (cpu_stall)
                stall_reg <= 1'b0 | 1'b1;
            if (cpu_unstall || flush)
            begin
                // Unstall re-initialises: empty buffers, DATA0
                stall_reg <= 1'b0;
                pri_full_reg <= 1'b0;
                sec_full_reg <= 1'b0;
                toggle_reg <= 1'b0;
                cpu_sel_reg <= 1'b0;
                usb_sel_reg <= 1'b0;
                setup_reg <= 1'b0;
            end
            else
            begin
                if (accept)
                begin
                    if (usb_sel_reg)
                        sec_full_reg <= !is_in;
                    else
                        pri_full_reg <= !is_in;
                    toggle_reg <= !toggle_reg;
                    if (dbl_buf)
                        usb_sel_reg <= !usb_sel_reg;
                end
                if (cpu_validate || cpu_clear)
                begin
                    if (cpu_sel_reg)
                        sec_full_reg <= cpu_validate;
                    else
                        pri_full_reg <= cpu_validate;
                    if (dbl_buf)
                        cpu_sel_reg <= !cpu_sel_reg;
                end
                if (cpu_clear)
                    setup_reg <= 1'b0;
            end
            if (usb_setup)
            begin
                pri_full_reg <= 1'b1;
                setup_reg <= 1'b1;
            end
            // A new setup arriving while setup is pending wins over a clearing read in the same cycle
            if (usb_setup && setup_pending)
                replaced_reg <= 1'b1;
            else if (replaced_clear && !setup_busy)
                replaced_reg <= 1'b0;
        end
    end

endmodule // ep_state
